// [hw/stc_pkg.sv]
// Shared constants and types for the transmit buffer configuration bank
package stc_pkg;

    // ==========================================================
    // Bus geometry and register indices (byte address = 4 * index)
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_W = ADDR_W - 2;
    localparam logic [IDX_W-1:0] IDX_TX_UCFG = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_CS_SW = 6'h0E;
    localparam logic [IDX_W-1:0] IDX_MSG_HI = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_MSG_LO = 6'h10;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h1C;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_TX_UCFG = 8'h00;
    localparam logic [7:0] RST_CS_SW = 8'h00;
    localparam logic [7:0] RST_MSG_HI = 8'h00;
    localparam logic [7:0] RST_MSG_LO = 8'h09;

    // ==========================================================
    // Field positions
    localparam int unsigned UCFG_IUZ_LSB = 4;
    localparam int unsigned UCFG_SEP_BIT = 3;
    localparam int unsigned UCFG_MODE_LSB = 1;
    localparam int unsigned UCFG_SIZE_BIT = 0;
    localparam int unsigned CS_SAME_BIT = 5;
    localparam int unsigned CS_NOCOPY_BIT = 4;
    localparam int unsigned CS_TXSW_BIT = 1;
    localparam int unsigned CS_RXSW_BIT = 0;
    localparam logic [7:0] CS_SW_MASK = 8'h33;
    localparam int unsigned ST_RSV_BIT = 0;
    localparam int unsigned ST_CLAMP_BIT = 1;

    // ==========================================================
    // Field values
    localparam logic [3:0] IU_ZERO_MAX = 4'h8;
    localparam logic [9:0] UBUF_BITS_SHORT = 10'h180;
    localparam logic [9:0] UBUF_BITS_LONG = 10'h300;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        UMODE_ZERO = 2'h0,
        UMODE_RAW = 2'h1,
        UMODE_IU = 2'h2,
        UMODE_RSV = 2'h3
    } stc_umode_type;

    typedef enum logic [1:0] {
        WS_COLLECT = 2'h1,
        WS_RESP = 2'h2
    } stc_wstate_type;

    typedef enum logic [1:0] {
        RS_IDLE = 2'h1,
        RS_DATA = 2'h2
    } stc_rstate_type;

endpackage

// [hw/stc_axil_port.sv]
// AXI4-Lite slave handshake engine for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module stc_axil_port #(
    parameter int unsigned AW = 8
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Write channels
    input wire logic [AW-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // Read channels
    input wire logic [AW-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // Register side
    output logic wr_en_out,
    output logic [AW-3:0] wr_idx_out,
    output logic [7:0] wr_data_out,
    output logic wr_strb0_out,
    input wire logic wr_ok_in,
    output logic [AW-3:0] rd_idx_out,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_ok_in
);
    import stc_pkg::*;

    stc_wstate_type wst_q, wst_d;
    stc_rstate_type rst_q, rst_d;
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [AW-1:0] waddr_q, waddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic aw_take, w_take, commit;

    // ==========================================================
    // Write path: address and data in either order
    always_comb begin
        aw_take = awvalid_in && awready_q;
        w_take = wvalid_in && wready_q;
        wst_d = wst_q;
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        commit = 1'b0;
        case (wst_q)
            WS_COLLECT: begin
                if (aw_take) begin
                    aw_held_d = 1'b1;
                    waddr_d = awaddr_in;
                end
                if (w_take) begin
                    w_held_d = 1'b1;
                    wdata_d = wdata_in[7:0];
                    wstrb_d = wstrb_in[0];
                end
                if (aw_held_d && w_held_d) begin
                    commit = 1'b1;
                    aw_held_d = 1'b0;
                    w_held_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = wr_ok_in ? RESP_OKAY : RESP_SLVERR;
                    wst_d = WS_RESP;
                end
            end
            WS_RESP: begin
                if (bready_in) begin
                    bvalid_d = 1'b0;
                    wst_d = WS_COLLECT;
                end
            end
            default: begin
                wst_d = WS_COLLECT;
                bvalid_d = 1'b0;
            end
        endcase
        awready_d = (wst_d == WS_COLLECT) && !aw_held_d;
        wready_d = (wst_d == WS_COLLECT) && !w_held_d;
    end

    assign wr_en_out = commit;
    assign wr_idx_out = aw_held_q ? waddr_q[AW-1:2] : awaddr_in[AW-1:2];
    assign wr_data_out = w_held_q ? wdata_q : wdata_in[7:0];
    assign wr_strb0_out = w_held_q ? wstrb_q : wstrb_in[0];

    // ==========================================================
    // Read path: data registered on the address handshake
    always_comb begin
        rst_d = rst_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        case (rst_q)
            RS_IDLE: begin
                if (arvalid_in && arready_q) begin
                    rvalid_d = 1'b1;
                    rdata_d = {24'h000000, rd_data_in};
                    rresp_d = rd_ok_in ? RESP_OKAY : RESP_SLVERR;
                    rst_d = RS_DATA;
                end
            end
            RS_DATA: begin
                if (rready_in) begin
                    rvalid_d = 1'b0;
                    rst_d = RS_IDLE;
                end
            end
            default: begin
                rst_d = RS_IDLE;
                rvalid_d = 1'b0;
            end
        endcase
        arready_d = (rst_d == RS_IDLE);
    end

    assign rd_idx_out = araddr_in[AW-1:2];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wst_q <= WS_COLLECT;
            rst_q <= RS_IDLE;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            wst_q <= wst_d;
            rst_q <= rst_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            bvalid_q <= bvalid_d;
            rvalid_q <= rvalid_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign awready_out = awready_q;
    assign wready_out = wready_q;
    assign arready_out = arready_q;
    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;
    assign rvalid_out = rvalid_q;
    assign rresp_out = rresp_q;
    assign rdata_out = rdata_q;
endmodule
`default_nettype wire

// [hw/stc_tx_cfg.sv]
// Transmit user-bit and channel-status buffer configuration bank
`timescale 1ns/1ps
`default_nettype none
module stc_tx_cfg (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // AXI4-Lite write
    input wire logic [stc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [stc_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // User-bit configuration
    output logic [3:0] iu_zero_count_out,
    output logic tx_user_separate_out,
    output logic [1:0] tx_user_buffer_mode_out,
    output logic tx_user_buffer_size_sel_out,
    output logic user_zero_fill_out,
    output logic user_raw_mode_out,
    output logic user_iu_mode_out,
    output logic [9:0] user_buf_bits_out,
    output logic [15:0] msg_zero_count_out,
    // Channel-status configuration
    output logic cs_share_a_out,
    output logic cs_copy_en_out,
    output logic tx_cs_bank_select_out,
    output logic rx_cs_bank_select_out
);
    import stc_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        idx_mapped = (idx == IDX_TX_UCFG) || (idx == IDX_CS_SW) ||
                     (idx == IDX_MSG_HI) || (idx == IDX_MSG_LO) ||
                     (idx == IDX_STATUS);
    endfunction

    function automatic logic [3:0] iu_clamp(input logic [3:0] v);
        iu_clamp = (v > IU_ZERO_MAX) ? IU_ZERO_MAX : v;
    endfunction

    logic wr_en, wr_strb0, wr_ok, rd_ok;
    logic [IDX_W-1:0] wr_idx, rd_idx;
    logic [7:0] wr_data, rd_data;

    // ==========================================================
    // Bus slave
    stc_axil_port #(.AW(ADDR_W)) u_port (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .awaddr_in(s_axi_awaddr_in),
        .awvalid_in(s_axi_awvalid_in),
        .awready_out(s_axi_awready_out),
        .wdata_in(s_axi_wdata_in),
        .wstrb_in(s_axi_wstrb_in),
        .wvalid_in(s_axi_wvalid_in),
        .wready_out(s_axi_wready_out),
        .bresp_out(s_axi_bresp_out),
        .bvalid_out(s_axi_bvalid_out),
        .bready_in(s_axi_bready_in),
        .araddr_in(s_axi_araddr_in),
        .arvalid_in(s_axi_arvalid_in),
        .arready_out(s_axi_arready_out),
        .rdata_out(s_axi_rdata_out),
        .rresp_out(s_axi_rresp_out),
        .rvalid_out(s_axi_rvalid_out),
        .rready_in(s_axi_rready_in),
        .wr_en_out(wr_en),
        .wr_idx_out(wr_idx),
        .wr_data_out(wr_data),
        .wr_strb0_out(wr_strb0),
        .wr_ok_in(wr_ok),
        .rd_idx_out(rd_idx),
        .rd_data_in(rd_data),
        .rd_ok_in(rd_ok)
    );

    // ==========================================================
    // Register state
    logic [7:0] ucfg_q, ucfg_d, cssw_q, cssw_d, mhi_q, mhi_d, mlo_q, mlo_d;
    logic [1:0] st_q, st_d, st_set, st_clr;
    logic zfill_q, zfill_d, raw_q, raw_d, iuf_q, iuf_d;
    logic cpen_q, cpen_d;
    logic [9:0] ubits_q, ubits_d;
    logic [3:0] iu_wr;
    logic [1:0] mode_wr;

    always_comb begin
        ucfg_d = ucfg_q;
        cssw_d = cssw_q;
        mhi_d = mhi_q;
        mlo_d = mlo_q;
        st_set = 2'h0;
        st_clr = 2'h0;
        iu_wr = wr_data[UCFG_IUZ_LSB +: 4];
        mode_wr = wr_data[UCFG_MODE_LSB +: 2];
        if (wr_en && wr_strb0) begin
            case (wr_idx)
                IDX_TX_UCFG: begin
                    ucfg_d[UCFG_IUZ_LSB +: 4] = iu_clamp(iu_wr);
                    st_set[ST_CLAMP_BIT] = (iu_wr > IU_ZERO_MAX);
                    ucfg_d[UCFG_SEP_BIT] = wr_data[UCFG_SEP_BIT];
                    ucfg_d[UCFG_SIZE_BIT] = wr_data[UCFG_SIZE_BIT];
                    if (mode_wr == UMODE_RSV) begin
                        st_set[ST_RSV_BIT] = 1'b1;
                    end else begin
                        ucfg_d[UCFG_MODE_LSB +: 2] = mode_wr;
                    end
                end
                IDX_CS_SW: cssw_d = wr_data & CS_SW_MASK;
                IDX_MSG_HI: mhi_d = wr_data;
                IDX_MSG_LO: mlo_d = wr_data;
                IDX_STATUS: st_clr = wr_data[1:0];
                default: ;
            endcase
        end
        // Set beats clear in the same cycle
        st_d = (st_q & ~st_clr) | st_set;
        zfill_d = (ucfg_d[UCFG_MODE_LSB +: 2] == UMODE_ZERO);
        raw_d = (ucfg_d[UCFG_MODE_LSB +: 2] == UMODE_RAW);
        iuf_d = (ucfg_d[UCFG_MODE_LSB +: 2] == UMODE_IU);
        ubits_d = ucfg_d[UCFG_SIZE_BIT] ? UBUF_BITS_LONG : UBUF_BITS_SHORT;
        cpen_d = !cssw_d[CS_NOCOPY_BIT];
    end

    assign wr_ok = idx_mapped(wr_idx);

    // ==========================================================
    // Read-back
    always_comb begin
        rd_ok = idx_mapped(rd_idx);
        case (rd_idx)
            IDX_TX_UCFG: rd_data = ucfg_q;
            IDX_CS_SW: rd_data = cssw_q;
            IDX_MSG_HI: rd_data = mhi_q;
            IDX_MSG_LO: rd_data = mlo_q;
            IDX_STATUS: rd_data = {6'h00, st_q};
            default: rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ucfg_q <= RST_TX_UCFG;
            cssw_q <= RST_CS_SW;
            mhi_q <= RST_MSG_HI;
            mlo_q <= RST_MSG_LO;
            st_q <= 2'h0;
            zfill_q <= 1'b1;
            raw_q <= 1'b0;
            iuf_q <= 1'b0;
            ubits_q <= UBUF_BITS_SHORT;
            cpen_q <= 1'b1;
        end else begin
            ucfg_q <= ucfg_d;
            cssw_q <= cssw_d;
            mhi_q <= mhi_d;
            mlo_q <= mlo_d;
            st_q <= st_d;
            zfill_q <= zfill_d;
            raw_q <= raw_d;
            iuf_q <= iuf_d;
            ubits_q <= ubits_d;
            cpen_q <= cpen_d;
        end
    end

    // ==========================================================
    // Outputs
    assign iu_zero_count_out = ucfg_q[UCFG_IUZ_LSB +: 4];
    assign tx_user_separate_out = ucfg_q[UCFG_SEP_BIT];
    assign tx_user_buffer_mode_out = ucfg_q[UCFG_MODE_LSB +: 2];
    assign tx_user_buffer_size_sel_out = ucfg_q[UCFG_SIZE_BIT];
    assign user_zero_fill_out = zfill_q;
    assign user_raw_mode_out = raw_q;
    assign user_iu_mode_out = iuf_q;
    assign user_buf_bits_out = ubits_q;
    assign msg_zero_count_out = {mhi_q, mlo_q};
    assign cs_share_a_out = cssw_q[CS_SAME_BIT];
    assign cs_copy_en_out = cpen_q;
    assign tx_cs_bank_select_out = cssw_q[CS_TXSW_BIT];
    assign rx_cs_bank_select_out = cssw_q[CS_RXSW_BIT];

    // ==========================================================
    // Checks
    logic ucfg_wr, cssw_wr;
    assign ucfg_wr = wr_en && wr_strb0 && (wr_idx == IDX_TX_UCFG);
    assign cssw_wr = wr_en && wr_strb0 && (wr_idx == IDX_CS_SW);

    a_iu_count_write: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ucfg_wr && (wr_data[7:4] <= IU_ZERO_MAX) |=>
        iu_zero_count_out == $past(wr_data[7:4]))
        else $error("IU zero count not stored");
    a_user_separate: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ucfg_wr |=> tx_user_separate_out == $past(wr_data[UCFG_SEP_BIT]))
        else $error("Separate flag not stored");
    a_rsv_mode_kept: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ucfg_wr && (wr_data[2:1] == UMODE_RSV) |=>
        $stable(tx_user_buffer_mode_out) && st_q[ST_RSV_BIT])
        else $error("Reserved mode accepted");
    a_zero_fill_mode: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ucfg_wr && (wr_data[2:1] == UMODE_ZERO) |=>
        user_zero_fill_out && !user_raw_mode_out && !user_iu_mode_out)
        else $error("Zero fill mode wrong");
    a_raw_mode_on: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ucfg_wr && (wr_data[2:1] == UMODE_RAW) |=> user_raw_mode_out)
        else $error("Raw mode not entered");
    a_iu_mode_on: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ucfg_wr && (wr_data[2:1] == UMODE_IU) |=> user_iu_mode_out && !user_zero_fill_out)
        else $error("Unit mode not entered");
    a_raw_buf_len: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        user_raw_mode_out |-> user_buf_bits_out ==
        (tx_user_buffer_size_sel_out ? 10'h300 : 10'h180))
        else $error("Raw buffer length wrong");
    a_cs_share_set: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        cssw_wr |=> cs_share_a_out == $past(wr_data[CS_SAME_BIT]))
        else $error("Share flag not stored");
    a_copy_inhibit: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        cssw_wr |=> cs_copy_en_out == !$past(wr_data[CS_NOCOPY_BIT]))
        else $error("Copy inhibit wrong");
    a_tx_bank_sel: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        cssw_wr |=> tx_cs_bank_select_out == $past(wr_data[CS_TXSW_BIT]))
        else $error("Transmit bank wrong");
    a_rx_bank_sel: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        cssw_wr |=> rx_cs_bank_select_out == $past(wr_data[CS_RXSW_BIT]))
        else $error("Receive bank wrong");
    a_msg_gap_reset: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(rstn_in) |-> msg_zero_count_out == 16'h0009)
        else $error("Message gap reset wrong");
    a_iu_clamp_max: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        ucfg_wr && (wr_data[7:4] > IU_ZERO_MAX) |=>
        iu_zero_count_out == 4'h8 && st_q[ST_CLAMP_BIT])
        else $error("IU count not clamped");
    a_iu_count_max: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        iu_zero_count_out <= IU_ZERO_MAX)
        else $error("IU count above eight");
    a_mode_not_rsv: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        tx_user_buffer_mode_out != UMODE_RSV)
        else $error("Reserved mode in use");
    a_one_user_mode: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $onehot({user_zero_fill_out, user_raw_mode_out, user_iu_mode_out}))
        else $error("User mode flags not one-hot");
    a_msg_hi_store: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        wr_en && wr_strb0 && (wr_idx == IDX_MSG_HI) |=>
        msg_zero_count_out[15:8] == $past(wr_data))
        else $error("Gap high byte not stored");
    a_msg_lo_store: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        wr_en && wr_strb0 && (wr_idx == IDX_MSG_LO) |=>
        msg_zero_count_out[7:0] == $past(wr_data))
        else $error("Gap low byte not stored");
endmodule
`default_nettype wire

// [dv/stc_tx_cfg_tb.sv]
// Self-checking testbench for the transmit buffer configuration bank
`timescale 1ns/1ps
`default_nettype none
module stc_tx_cfg_tb;
    import stc_pkg::*;
    // ==========================================================
    // Clock, reset and bus signals
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [3:0] iu_cnt;
    logic sep;
    logic [1:0] mode;
    logic size_sel;
    logic zfill;
    logic raw;
    logic iu_mode;
    logic [9:0] buf_bits;
    logic [15:0] msg_cnt;
    logic share_a;
    logic copy_en;
    logic tx_bank;
    logic rx_bank;
    int fail_count = 0;
    int cmp_count = 0;
    always #4 sys_clk = ~sys_clk;
    stc_tx_cfg DUT (.sys_clk_in(sys_clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .iu_zero_count_out(iu_cnt), .tx_user_separate_out(sep),
        .tx_user_buffer_mode_out(mode), .tx_user_buffer_size_sel_out(size_sel),
        .user_zero_fill_out(zfill), .user_raw_mode_out(raw), .user_iu_mode_out(iu_mode),
        .user_buf_bits_out(buf_bits), .msg_zero_count_out(msg_cnt), .cs_share_a_out(share_a),
        .cs_copy_en_out(copy_en), .tx_cs_bank_select_out(tx_bank),
        .rx_cs_bank_select_out(rx_bank));
    // ==========================================================
    // Verdict, compare and bus tasks
    task automatic give_verdict();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        cmp_count++;
        if (act !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic wait_fail(input logic done);
        if (!done) begin
            fail_count++;
            $display("mismatch at %0t: bus answer timed out", $time);
            give_verdict();
        end
    endtask
    task automatic axi_write(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] st,
                             output logic [1:0] resp);
        int n;
        logic done;
        done = 1'b0;
        resp = 2'h3;
        @(posedge sys_clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        wait_fail(done);
    endtask
    task automatic axi_read(input logic [5:0] idx, output logic [31:0] d,
                            output logic [1:0] resp);
        int n;
        logic done;
        done = 1'b0;
        d = 32'hX;
        resp = 2'h3;
        @(posedge sys_clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50 && !done; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        wait_fail(done);
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_write(idx, d, 4'hF, r);
        chk(r, RESP_OKAY);
    endtask
    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(idx, d, r);
        chk(d, exp);
        chk(r, er);
    endtask
    // ==========================================================
    // Scenarios
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic check_reset();
        chk(msg_cnt, 32'h0009);
        chk({zfill, raw, iu_mode, buf_bits}, {3'h4, 10'h180});
        chk({share_a, copy_en, tx_bank, rx_bank}, 4'h4);
        rd_chk(IDX_TX_UCFG, 32'h00, RESP_OKAY);
        rd_chk(IDX_CS_SW, 32'h00, RESP_OKAY);
        rd_chk(IDX_MSG_HI, 32'h00, RESP_OKAY);
        rd_chk(IDX_MSG_LO, 32'h09, RESP_OKAY);
    endtask
    task automatic test_modes();
        logic [7:0] d;
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 2; s++) begin
                d = {4'h3, s[0], m[1:0], s[0]};
                wr(IDX_TX_UCFG, d);
                chk({sep, mode, size_sel}, {s[0], m[1:0], s[0]});
                chk({zfill, raw, iu_mode}, {m == 0, m == 1, m == 2});
                chk(buf_bits, s[0] ? 10'h300 : 10'h180);
                rd_chk(IDX_TX_UCFG, {24'h0, d}, RESP_OKAY);
            end
        end
    endtask
    task automatic test_iu_clamp();
        logic [3:0] e;
        for (int v = 0; v < 16; v++) begin
            e = (v > 8) ? 4'h8 : v[3:0];
            wr(IDX_TX_UCFG, {v[3:0], 4'h2});
            chk(iu_cnt, e);
            rd_chk(IDX_TX_UCFG, {24'h0, e, 4'h2}, RESP_OKAY);
        end
        rd_chk(IDX_STATUS, 32'h02, RESP_OKAY);
        wr(IDX_STATUS, 8'h03);
        rd_chk(IDX_STATUS, 32'h00, RESP_OKAY);
    endtask
    task automatic test_reserved_mode();
        wr(IDX_TX_UCFG, 8'h5A);
        wr(IDX_TX_UCFG, 8'h87);
        chk({iu_cnt, sep, mode, size_sel}, 8'h83);
        rd_chk(IDX_TX_UCFG, 32'h83, RESP_OKAY);
        rd_chk(IDX_STATUS, 32'h01, RESP_OKAY);
        wr(IDX_STATUS, 8'h01);
    endtask
    task automatic test_cs_switch();
        logic [7:0] pats [4] = '{8'hFF, 8'h00, 8'h21, 8'h12};
        foreach (pats[i]) begin
            wr(IDX_CS_SW, pats[i]);
            chk({share_a, copy_en}, {pats[i][5], ~pats[i][4]});
            chk({tx_bank, rx_bank}, pats[i][1:0]);
            rd_chk(IDX_CS_SW, {24'h0, pats[i] & 8'h33}, RESP_OKAY);
        end
    endtask
    task automatic test_msg_and_refusals();
        logic [1:0] r;
        wr(IDX_MSG_HI, 8'hA5);
        wr(IDX_MSG_LO, 8'h3C);
        chk(msg_cnt, 32'hA53C);
        axi_write(IDX_MSG_LO, 8'h77, 4'hE, r);
        chk(r, RESP_OKAY);
        chk(msg_cnt, 32'hA53C);
        axi_write(6'h05, 8'h55, 4'hF, r);
        chk(r, RESP_SLVERR);
        rd_chk(6'h05, 32'h0, RESP_SLVERR);
        rd_chk(IDX_MSG_HI, 32'hA5, RESP_OKAY);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        do_reset();
        check_reset();
        test_modes();
        test_iu_clamp();
        test_reserved_mode();
        test_cs_switch();
        test_msg_and_refusals();
        do_reset();
        check_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
